// >>> src/ebcs_match.v
// address window compare for one chip select
`timescale 1ns/100ps
`include "ebcs_regs.vh"
module ebcs_match (
   // configuration
   input wire [31:0] i_ctrl,
   // cycle address, bit 31 already stripped
   input wire [30:0] i_addr,
   // result
   output wire o_hit
);
   // size code n up to 13 covers 8 KB << n, ignoring the low 13+n address bits; codes 14 and 15 still compare bit 13
   function [30:0] ebcs_size_mask;
      input [3:0] code;
      begin
         ebcs_size_mask = ~((31'h1fff << code) | 31'h1fff) & 31'h7fffffff;
      end
   endfunction

   wire [30:0] mask;
   wire [30:0] base;
   assign mask = ebcs_size_mask(i_ctrl[`EBCS_F_SIZE_HI:`EBCS_F_SIZE_LO]);
   assign base = {i_ctrl[30:`EBCS_F_BASE_LO], 12'h000};
   assign o_hit = i_ctrl[`EBCS_F_EN] & (((i_addr ^ base) & mask) == 31'h0);
endmodule // ebcs_match

// >>> src/ebcs_regs.vh
// register offsets, field positions, reset values and timing constants of the external bus chip select block
`ifndef EBCS_REGS_VH
`define EBCS_REGS_VH

// ==========================================
// register map (byte addresses, one word each)
`define EBCS_ADDR_W 8
`define EBCS_OFS_CTRL0 8'h00
`define EBCS_OFS_STATUS 8'h20
`define EBCS_OFS_CTX 8'h24
`define EBCS_MASTER_CTX 3'h0

// ==========================================
// control register fields
`define EBCS_F_BASE_HI 31
`define EBCS_F_BASE_LO 12
`define EBCS_F_MODE 10
`define EBCS_F_EN 9
`define EBCS_F_DYN 8
`define EBCS_F_WID_HI 7
`define EBCS_F_WID_LO 6
`define EBCS_F_BYTE 5
`define EBCS_F_SIZE_HI 3
`define EBCS_F_SIZE_LO 0
`define EBCS_CTRL_MASK 32'hfffff7ef
`define EBCS_WID_8 2'h0
`define EBCS_WID_16 2'h1

// ==========================================
// reset values
`define EBCS_RST_CS0_8 32'h00000205
`define EBCS_RST_CS0_16 32'h00000245
`define EBCS_RST_CSN 32'h00000000

// ==========================================
// timing: no-select cycles wait for ready until the counter reaches this value, 256 clocks in all
`define EBCS_RDY_TIMEOUT_CLKS 8'hff
`define EBCS_MCLK_DIV_W 1

`endif

// >>> src/ebcs_top.v
// external bus chip select decode: control registers, select decode, pin drive, ready timeout
// Contract
// - 31-bit address, 8/16-bit data, 32-bit internal
// - size strap sampled at reset sets width
// - unclaimed cycle ends on ready, fault after 256 clocks
// - address bit 31 selects little endian
// - eight control registers, context zero writes only
// - bit 10 picks select or address pin
// - bit 9 enables select; off tristates/drives high
// - dynamic mode ignores width and strobe fields
// - width 00 byte, 01 halfword with split
// - select zero width comes from strap only
// - bit 5 makes strobes write-only
// - size code doubles from 8K to 256M; logic doubles only to 64M, codes 14 and 15 still compare bit 13
// - reset values of select zero and others
// - dynamic select driven by same-index bank
// - external master request answered by grant
// - memory clock out, active-low strobes, tristates
`timescale 1ns/100ps
`include "ebcs_regs.vh"
module ebcs_top (
   // clock and reset
   input wire i_core_clk,
   input wire i_rst,
   input wire i_size_strap,
   // register port
   input wire [`EBCS_ADDR_W-1:0] i_reg_addr,
   input wire [31:0] i_reg_wdata,
   input wire i_reg_wr,
   input wire i_reg_rd,
   input wire [2:0] i_reg_ctx,
   output reg [31:0] o_reg_rdata,
   // internal cycle request
   input wire i_cyc_start,
   input wire [31:0] i_cyc_addr,
   input wire i_cyc_write,
   input wire [1:0] i_cyc_bytes,
   output reg o_cyc_done,
   output reg o_bus_fault,
   output reg o_cyc_split,
   output reg o_cyc_little_endian,
   // dynamic memory controller bank selects, active low
   input wire [7:0] i_dyn_bank_sel_n,
   output reg [7:0] o_dyn_region,
   // external pins
   output reg o_memory_clock_out,
   output reg [24:0] o_addr,
   output reg o_addr_oe_n,
   output reg o_select0_out_n,
   output reg [2:0] o_select1to3_out_n,
   output reg o_shared_pin_sel4_addr30,
   output reg o_shared_pin_sel5_addr29,
   output reg o_shared_pin_sel6_addr28,
   output reg o_shared_pin_sel7_addr27,
   output reg [3:0] o_shared_pin_oe_n,
   output reg o_byte_lane_strobe_hi_n,
   output reg o_byte_lane_strobe_lo_n,
   output reg o_out_enable_n,
   output reg o_write_n,
   output reg o_ctrl_oe_n,
   output reg o_wide_bus,
   input wire i_ready_n,
   input wire i_ext_master_request_n,
   output reg o_ext_master_grant_n
);

   // ==========================================
   // state
   localparam ST_IDLE = 3'b001;
   localparam ST_SEL = 3'b010;
   localparam ST_EXT = 3'b100;

   reg [31:0] ctrl_reg [0:7];
   reg strap_done_reg;
   reg wide_reg;
   reg [2:0] st_reg;
   reg [2:0] st_next;
   reg [7:0] tmo_reg;
   reg [7:0] tmo_next;
   reg [30:0] cyc_addr_reg;
   reg [7:0] hit_reg;
   reg write_reg;
   reg [1:0] bytes_reg;
   reg little_reg;
   reg fault_reg;
   reg split_reg;
   reg [31:0] rdata_next;
   wire [7:0] hit;
   integer k;
   integer m;
   integer j;

   // write permission check used by the register port
   function ebcs_wr_ok;
      input [2:0] ctx;
      begin
         ebcs_wr_ok = (ctx == `EBCS_MASTER_CTX);
      end
   endfunction

   // ==========================================
   // window compare per select
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_match
         ebcs_match u_match (
            .i_ctrl(ctrl_reg[g]),
            .i_addr(i_cyc_addr[30:0]),
            .o_hit(hit[g])
         );
      end
   endgenerate

   // ==========================================
   // strap capture: taken on the first clock after reset release
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         strap_done_reg <= 1'b0;
         wide_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         wide_reg <= i_size_strap;
      end
   end

   // ==========================================
   // control registers
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_reg[0] <= `EBCS_RST_CS0_8;
         for (k = 1; k < 8; k = k + 1) begin
            ctrl_reg[k] <= `EBCS_RST_CSN;
         end
      end else begin
         if (!strap_done_reg) begin
            ctrl_reg[0][`EBCS_F_WID_HI:`EBCS_F_WID_LO] <= i_size_strap ? `EBCS_WID_16 : `EBCS_WID_8;
         end
         if (i_reg_wr && ebcs_wr_ok(i_reg_ctx) && i_reg_addr < `EBCS_OFS_STATUS
               && i_reg_addr[1:0] == 2'h0) begin
            if (i_reg_addr[4:2] == 3'h0) begin
               // width of select zero stays as strapped
               ctrl_reg[0] <= (i_reg_wdata & `EBCS_CTRL_MASK & 32'hffffff3f)
                  | {24'h000000, ctrl_reg[0][7:6], 6'h00};
            end else begin
               ctrl_reg[i_reg_addr[4:2]] <= i_reg_wdata & `EBCS_CTRL_MASK;
            end
         end
      end
   end

   // ==========================================
   // register reads, data in the cycle after the strobe
   always @* begin
      rdata_next = 32'h00000000;
      if (i_reg_addr < `EBCS_OFS_STATUS && i_reg_addr[1:0] == 2'h0) begin
         rdata_next = ctrl_reg[i_reg_addr[4:2]];
      end else if (i_reg_addr == `EBCS_OFS_STATUS) begin
         rdata_next = {23'h0, fault_reg, wide_reg, st_reg, tmo_reg[3:0]};
      end
   end

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= 32'h00000000;
      end else begin
         o_reg_rdata <= i_reg_rd ? rdata_next : 32'h00000000;
      end
   end

   // ==========================================
   // cycle sequencer
   always @* begin
      st_next = st_reg;
      tmo_next = tmo_reg;
      case (st_reg)
         ST_IDLE: begin
            tmo_next = 8'h00;
            if (i_cyc_start && o_ext_master_grant_n) begin
               st_next = (hit != 8'h00) ? ST_SEL : ST_EXT;
            end
         end
         ST_SEL: begin
            st_next = ST_IDLE;
         end
         ST_EXT: begin
            tmo_next = tmo_reg + 8'h01;
            if (!i_ready_n || tmo_reg == `EBCS_RDY_TIMEOUT_CLKS) begin
               st_next = ST_IDLE;
            end
         end
         default: begin
            st_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= ST_IDLE;
         tmo_reg <= 8'h00;
         cyc_addr_reg <= 31'h0;
         hit_reg <= 8'h00;
         write_reg <= 1'b0;
         bytes_reg <= 2'h0;
         little_reg <= 1'b0;
         fault_reg <= 1'b0;
         split_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         tmo_reg <= tmo_next;
         if (st_reg == ST_IDLE && st_next != ST_IDLE) begin
            cyc_addr_reg <= i_cyc_addr[30:0];
            hit_reg <= hit;
            write_reg <= i_cyc_write;
            bytes_reg <= i_cyc_bytes;
            little_reg <= i_cyc_addr[31];
            // a halfword to an odd address on a halfword device needs two bus cycles
            split_reg <= i_cyc_addr[0] && (i_cyc_bytes == 2'h3);
         end
         if (st_reg == ST_EXT && i_ready_n && tmo_reg == `EBCS_RDY_TIMEOUT_CLKS) begin
            fault_reg <= 1'b1;
         end else if (i_reg_wr && ebcs_wr_ok(i_reg_ctx) && i_reg_addr == `EBCS_OFS_STATUS) begin
            fault_reg <= 1'b0;
         end
      end
   end

   // ==========================================
   // pin drive
   reg [7:0] sel_n;
   reg [1:0] lane_n;
   reg [31:0] act;
   reg act_on;
   reg grant_n_next;

   // grant only between cycles; internal cycles are refused while granted
   // the bus enables follow this value so they float in the same cycle as the grant
   always @* begin
      grant_n_next = o_ext_master_grant_n;
      if (i_ext_master_request_n) begin
         grant_n_next = 1'b1;
      end else if (st_reg == ST_IDLE && !i_cyc_start) begin
         grant_n_next = 1'b0;
      end
   end

   always @* begin
      sel_n = 8'hff;
      act = 32'h00000000;
      act_on = (st_reg != ST_IDLE);
      for (m = 0; m < 8; m = m + 1) begin
         if (ctrl_reg[m][`EBCS_F_DYN]) begin
            sel_n[m] = i_dyn_bank_sel_n[m];
         end else if (act_on && hit_reg[m]) begin
            sel_n[m] = 1'b0;
            act = ctrl_reg[m];
         end
      end
      // 8-bit ports use only the low lane; halfword ports pick lanes from the cycle byte enables
      if (act[`EBCS_F_WID_HI:`EBCS_F_WID_LO] == `EBCS_WID_16) begin
         lane_n = ~bytes_reg;
      end else begin
         lane_n = 2'b10;
      end
      if (!act_on) begin
         lane_n = 2'b11;
      end else if (act[`EBCS_F_BYTE] && !write_reg) begin
         lane_n = 2'b11;
      end
   end

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_memory_clock_out <= 1'b0;
         o_addr <= 25'h0;
         o_addr_oe_n <= 1'b1;
         o_select0_out_n <= 1'b1;
         o_select1to3_out_n <= 3'h7;
         o_shared_pin_sel4_addr30 <= 1'b1;
         o_shared_pin_sel5_addr29 <= 1'b1;
         o_shared_pin_sel6_addr28 <= 1'b1;
         o_shared_pin_sel7_addr27 <= 1'b1;
         o_shared_pin_oe_n <= 4'hf;
         o_byte_lane_strobe_hi_n <= 1'b1;
         o_byte_lane_strobe_lo_n <= 1'b1;
         o_out_enable_n <= 1'b1;
         o_write_n <= 1'b1;
         o_ctrl_oe_n <= 1'b1;
         o_wide_bus <= 1'b0;
         o_cyc_done <= 1'b0;
         o_bus_fault <= 1'b0;
         o_cyc_split <= 1'b0;
         o_cyc_little_endian <= 1'b0;
         o_dyn_region <= 8'h00;
         o_ext_master_grant_n <= 1'b1;
      end else begin
         o_memory_clock_out <= ~o_memory_clock_out;
         // the width pin settles on the strap edge itself and never moves after
         o_wide_bus <= strap_done_reg ? wide_reg : i_size_strap;
         o_addr <= cyc_addr_reg[24:0];
         o_addr_oe_n <= ~grant_n_next;
         o_ctrl_oe_n <= ~grant_n_next;
         o_select0_out_n <= sel_n[0] | ~ctrl_reg[0][`EBCS_F_EN];
         for (j = 1; j < 4; j = j + 1) begin
            o_select1to3_out_n[j-1] <= sel_n[j] | ~ctrl_reg[j][`EBCS_F_EN];
         end
         // shared pins: select when mode is 0, address bit when 1
         o_shared_pin_sel4_addr30 <= ctrl_reg[4][`EBCS_F_MODE] ? cyc_addr_reg[30] : sel_n[4];
         o_shared_pin_sel5_addr29 <= ctrl_reg[5][`EBCS_F_MODE] ? cyc_addr_reg[29] : sel_n[5];
         o_shared_pin_sel6_addr28 <= ctrl_reg[6][`EBCS_F_MODE] ? cyc_addr_reg[28] : sel_n[6];
         o_shared_pin_sel7_addr27 <= ctrl_reg[7][`EBCS_F_MODE] ? cyc_addr_reg[27] : sel_n[7];
         for (j = 4; j < 8; j = j + 1) begin
            o_shared_pin_oe_n[j-4] <= ~ctrl_reg[j][`EBCS_F_EN] | ~grant_n_next;
         end
         o_byte_lane_strobe_hi_n <= lane_n[1];
         o_byte_lane_strobe_lo_n <= lane_n[0];
         o_out_enable_n <= ~(act_on && !write_reg);
         o_write_n <= ~(act_on && write_reg);
         o_cyc_done <= (st_reg == ST_SEL) || (st_reg == ST_EXT && st_next == ST_IDLE);
         o_bus_fault <= (st_reg == ST_EXT) && i_ready_n && (tmo_reg == `EBCS_RDY_TIMEOUT_CLKS);
         o_cyc_split <= split_reg && act[`EBCS_F_WID_HI:`EBCS_F_WID_LO] == `EBCS_WID_16;
         o_cyc_little_endian <= little_reg;
         for (j = 0; j < 8; j = j + 1) begin
            o_dyn_region[j] <= ctrl_reg[j][`EBCS_F_DYN];
         end
         o_ext_master_grant_n <= grant_n_next;
      end
   end
endmodule // ebcs_top

// >>> tb/ebcs_ext_dev.sv
// far side model: external ready source and external bus master
`timescale 1ns/100ps
module ebcs_ext_dev (
   // clock and reset
   input wire i_core_clk,
   input wire i_rst,
   // bench commands
   input wire i_go,
   input wire [8:0] i_delay,
   input wire i_hold,
   // pins toward the block
   output wire o_ready_n,
   output wire o_ext_master_request_n
);
   logic [8:0] left_reg;
   // ready is one clock wide: a slow sampler gets no second chance
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst)
         left_reg <= 9'h0;
      else if (i_go)
         left_reg <= i_delay;
      else if (left_reg != 9'h0)
         left_reg <= left_reg - 9'h1;
   end
   assign o_ready_n = (left_reg != 9'h1);
   assign o_ext_master_request_n = ~i_hold;
endmodule // ebcs_ext_dev

// >>> tb/ebcs_top_sva.sv
// port checker for the chip select block
`timescale 1ns/100ps
module ebcs_top_sva (
   // clock and reset
   input wire i_core_clk,
   input wire i_rst,
   // register and cycle side
   input wire i_reg_rd,
   input wire [31:0] o_reg_rdata,
   input wire i_cyc_start,
   input wire o_cyc_done,
   input wire o_bus_fault,
   // pins
   input wire o_select0_out_n,
   input wire [2:0] o_select1to3_out_n,
   input wire [7:0] o_dyn_region,
   input wire o_memory_clock_out,
   input wire o_addr_oe_n,
   input wire [3:0] o_shared_pin_oe_n,
   input wire i_ext_master_request_n,
   input wire o_ext_master_grant_n,
   input wire o_wide_bus
);
   // ==========
   // cycle age: 1 after the start edge, cleared by done
   logic [8:0] age_reg;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst)
         age_reg <= 9'h0;
      else if (o_cyc_done)
         age_reg <= 9'h0;
      else if (i_cyc_start && age_reg == 9'h0 && o_ext_master_grant_n)
         age_reg <= 9'h1;
      else if (age_reg != 9'h0)
         age_reg <= age_reg + 9'h1;
   end
   // ==========
   // properties
   a_rdata_idle_zero: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
      else $error("read data outside answer slot");
   a_done_one_cycle: assert property (o_cyc_done |=> !o_cyc_done)
      else $error("done longer than one cycle");
   a_fault_at_limit: assert property (o_bus_fault |-> o_cyc_done && age_reg == 9'h101)
      else $error("fault at wrong moment");
   a_cycle_age_bound: assert property (age_reg <= 9'h101)
      else $error("cycle outlived ready timeout");
   // selects handed to the dynamic memory banks follow those banks, not the cycle
   a_select_in_slot: assert property (((!o_select0_out_n && !o_dyn_region[0])
      || ((~o_select1to3_out_n & ~o_dyn_region[3:1]) != 3'h0)) |->
      o_cyc_done && age_reg == 9'h2)
      else $error("select low outside its cycle");
   a_memory_clock_out_half_rate: assert property (!$past(i_rst) |-> o_memory_clock_out != $past(o_memory_clock_out))
      else $error("memory clock not half rate");
   a_grant_floats_bus: assert property (!o_ext_master_grant_n |-> o_addr_oe_n && (&o_shared_pin_oe_n))
      else $error("bus driven while granted");
   a_grant_needs_req: assert property ($fell(o_ext_master_grant_n) |-> !$past(i_ext_master_request_n))
      else $error("grant without request");
   a_width_latched: assert property (!$past(i_rst, 2) |-> $stable(o_wide_bus))
      else $error("bus width moved after reset");
endmodule // ebcs_top_sva

// >>> tb/ebcs_top_tb.sv
// self-checking bench for the chip select block
`timescale 1ns/100ps
module ebcs_top_tb;
   // ==========
   // stimulus and observation
   logic clk, rst, strap, reg_rd, reg_wr, start, cw, go, hold, rd_d, sb, w;
   logic [7:0] ra, bk;
   logic [31:0] wd, ca, a;
   logic [2:0] ctx;
   logic [1:0] cb;
   logic [8:0] dly;
   wire [31:0] rdata;
   wire [2:0] sel13_n;
   wire done, fault, split, le, wide, rdy_n, req_n, gnt_n, sel0_n, wn, oen, bh, bl, sh4, coe;
   wire [24:0] addr;
   wire [7:0] dynr;
   wire [3:0] shoe;
   int errors, total_checks, n;
   logic [31:0] rq[$];
   logic [35:0] cq[$];
   ebcs_top ebcs_top_inst (.i_core_clk(clk), .i_rst(rst), .i_size_strap(strap), .i_reg_addr(ra),
      .i_reg_wdata(wd), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_ctx(ctx), .o_reg_rdata(rdata),
      .i_cyc_start(start), .i_cyc_addr(ca), .i_cyc_write(cw), .i_cyc_bytes(cb), .o_cyc_done(done),
      .o_bus_fault(fault), .o_cyc_split(split), .o_cyc_little_endian(le), .i_dyn_bank_sel_n(bk),
      .o_dyn_region(dynr), .o_memory_clock_out(), .o_addr(addr), .o_addr_oe_n(), .o_select0_out_n(sel0_n),
      .o_select1to3_out_n(sel13_n), .o_shared_pin_sel4_addr30(sh4), .o_shared_pin_sel5_addr29(),
      .o_shared_pin_sel6_addr28(), .o_shared_pin_sel7_addr27(), .o_shared_pin_oe_n(shoe),
      .o_byte_lane_strobe_hi_n(bh), .o_byte_lane_strobe_lo_n(bl), .o_out_enable_n(oen), .o_write_n(wn),
      .o_ctrl_oe_n(coe), .o_wide_bus(wide), .i_ready_n(rdy_n), .i_ext_master_request_n(req_n),
      .o_ext_master_grant_n(gnt_n));
   ebcs_ext_dev ebcs_ext_dev_inst (.i_core_clk(clk), .i_rst(rst), .i_go(go), .i_delay(dly), .i_hold(hold),
      .o_ready_n(rdy_n), .o_ext_master_request_n(req_n));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task check(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // strap is held through reset and flipped once latched
   task do_reset(input logic s);
      strap <= s;
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      strap <= ~s;
      #1;
   endtask
   task reg_write(input logic [7:0] ad, input logic [31:0] d, input logic [2:0] c);
      @(posedge clk);
      ra <= ad;
      wd <= d;
      ctx <= c;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task reg_read(input logic [7:0] ad, input logic [31:0] e);
      rq.push_back(e);
      @(posedge clk);
      ra <= ad;
      ctx <= 3'($urandom);
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   // one gap cycle on each side keeps the sequencer idle at start
   // direction comes from w; the note holds address, write, output enable and e
   task cyc(input logic [31:0] ad, input logic [1:0] b, input logic [8:0] d, input logic [8:0] e);
      int k;
      cq.push_back({ad[24:0], ~w, w, e});
      @(posedge clk);
      start <= 1'b1;
      ca <= ad;
      cb <= b;
      cw <= w;
      go <= 1'b1;
      dly <= d;
      @(posedge clk);
      start <= 1'b0;
      go <= 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 300) begin
         @(posedge clk);
         k++;
      end
      if (k == 300)
         errors++;
      @(posedge clk);
   endtask
   always @(posedge clk or posedge rst) begin
      if (rst)
         rd_d <= 1'b0;
      else begin
         if (rd_d)
            check(rdata, rq.pop_front());
         if (done === 1'b1)
            check({addr, wn, oen, bh, bl, fault, le, split, sel0_n, sel13_n}, cq.pop_front());
         rd_d <= reg_rd;
      end
   end
   initial begin
      {rst, strap, reg_rd, reg_wr, start, cw, go, hold, w, ra, wd, ca, ctx, cb, dly} = '0;
      bk = 8'hff;
      void'($urandom(32'h9ae0));
      for (int s = 0; s < 2; s++) begin
         sb = s[0];
         do_reset(sb);
         check(wide, sb);
         reg_read(8'h00, 32'h00000205 | {sb, 6'h0});
         for (int i = 1; i < 8; i++)
            reg_read(8'(4 * i), 32'h0);
         reg_read(8'h28, 32'h0);
         reg_write(8'h04, $urandom, 3'(1 + $urandom % 7));
         reg_read(8'h04, 32'h0);
         reg_write(8'h00, 32'hffffffff, 3'h0);
         reg_read(8'h00, 32'hfffff72f | {sb, 6'h0});
         // select four as address pin, parked far above every test address
         reg_write(8'h10, 32'h70000600, 3'h0);
         // aligned 256K region with byte strobes on writes only
         reg_write(8'h00, 32'h00000225, 3'h0);
         w = 1'($urandom);
         a = $urandom & 32'h8003ffff;
         cyc(a, 2'h3, 9'h0, {w ? {~sb, 1'b0} : 2'b11, 1'b0, a[31], sb & a[0], 4'h7});
         a = {1'($urandom), 31'h40000};
         cyc(a, 2'h1, 9'h5, {2'b10, 1'b0, a[31], 1'b0, 4'hf});
         cyc(32'h40000, 2'h1, 9'h0, {2'b10, 3'h4, 4'hf});
         reg_read(8'h20, {23'h0, 1'b1, sb, 7'h10});
         reg_write(8'h20, 32'h0, 3'h0);
         reg_read(8'h20, {23'h0, 1'b0, sb, 7'h10});
         reg_write(8'h00, 32'h00000005, 3'h0);
         cyc(32'h0, 2'h1, 9'h3, {2'b10, 3'h0, 4'hf});
         check(sh4, 1'b0);
         check({shoe, coe}, 5'h1c);
         // select one handed to dynamic bank one, base low bits zero
         reg_write(8'h04, 32'h00100305, 3'h0);
         bk <= 8'hfd;
         repeat (2) @(posedge clk);
         check({dynr, sel13_n}, {8'h02, 3'h6});
         bk <= 8'hff;
         hold <= 1'b1;
         n = 0;
         while (gnt_n !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
         end
         check(gnt_n, 1'b0);
         hold <= 1'b0;
      end
      print_verdict;
   end
   initial begin
      #200000;
      errors++;
      $display("wrong value at %0t: run did not finish", $time);
      print_verdict;
   end
endmodule // ebcs_top_tb
bind ebcs_top ebcs_top_sva ebcs_top_sva_inst (.i_core_clk, .i_rst, .i_reg_rd, .o_reg_rdata, .i_cyc_start,
   .o_cyc_done, .o_bus_fault, .o_select0_out_n, .o_select1to3_out_n, .o_dyn_region, .o_memory_clock_out, .o_addr_oe_n,
   .o_shared_pin_oe_n, .i_ext_master_request_n, .o_ext_master_grant_n, .o_wide_bus);
